// ==== hw/tx_burst_pkg.sv ====
package tx_burst_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int TICK_HZ        = 48_600;      // Sample tick rate
    localparam int SYMBOL_HZ      = 24_300;      // Symbol rate
    localparam int QUARTERS       = 4;           // Quarter ticks per tick
    // Quarter tick in clocks, rounded to nearest
    localparam int QUARTER_CYCLES =
        (CLK_HZ + (QUARTERS * TICK_HZ) / 2) / (QUARTERS * TICK_HZ);

    // Sequencer spans in quarter ticks (ticks times four)
    localparam logic [7:0] HOLD_Q  = 8'h26;      // 9.5 ticks
    localparam logic [7:0] RAMP_Q  = 8'h18;      // 6 ticks
    localparam logic [7:0] FLUSH_Q = 8'h36;      // 15.5 - 2 ticks
    localparam logic [7:0] DECAY_Q = 8'h18;      // 6 ticks

    // Fixed envelope shape
    localparam logic [7:0] RAMP_STEP  = 8'h0a;
    localparam logic [7:0] PEAK_LEVEL = 8'hf0;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_INPHASE    = 8'h04;
    localparam logic [7:0] OFS_QUADRATURE = 8'h08;
    localparam logic [7:0] OFS_BASE_DELAY = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    localparam int BIT_BURST_GO = 0;
    localparam int BIT_MODE     = 1;
    localparam int DATA_W       = 10;            // Five dibits
    localparam int SAMPLE_W     = 8;

    localparam logic CTRL_GO_RST   = 1'b0;
    localparam logic CTRL_MODE_RST = 1'b1;       // Digital mode

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_RAMP_UP,
        ST_BURST,
        ST_DECAY
    } seq_state_t;

endpackage

// ==== hw/tx_burst_sequencer.sv ====
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE_01] Sample tick runs at 48.6 kHz, half a 24.3 kHz symbol.
// [RULE_02] Software loads one to five dibits, delay offset, then burst-go.
// [RULE_03] Burst-go is sampled only at the falling edge of the tick.
// [RULE_04] Outputs stay at zero 9.5 ticks plus offset after sampled go.
// [RULE_05] Amplifier enable rises together with the ramp-up start.
// [RULE_06] Peak level is reached six ticks after ramp-up starts.
// [RULE_07] Data shifts right once per tick, bit 0 leaving first.
// [RULE_08] Data flushes; decay starts 13.5 ticks plus offset after go falls. Shifting here stops after the tick fall that samples go low.
// [RULE_09] Decay lasts six ticks, then amplifier enable drops.
// [RULE_10] Offset delays waveform and enable in quarter tick steps.
// [RULE_11] Offset takes 0 to 3, each step a quarter tick.
// [RULE_12] Software makes whole tick delays by writing later.
// [RULE_13] Enable to waveform timing does not depend on the offset.
// [RULE_14] Burst length follows how long burst-go stays high.
// [RULE_15] Digital outputs carry only the fixed ramp level shaping.
// [RULE_16] Analog outputs are exactly the written sample values.
// [RULE_17] Software slightly attenuates analog samples for power match.
// [RULE_18] Mode bit: 1 selects digital, 0 selects analog.
// [RULE_19] In analog mode amplifier enable stays high.
// [RULE_20] Quarter tick timebase locked to the tick times all events.
module tx_burst_sequencer
(
    input  wire logic        pclk,                  // Bus clock, 20 MHz
    input  wire logic        presetn,               // Async reset, low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB access phase
    input  wire logic        pwrite,                // APB write
    input  wire logic [7:0]  paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    output logic             sample_tick_interrupt, // Tick to DSP
    output logic             power_amp_enable,      // Amplifier enable
    output logic             mod_bit,               // Serial modulator bit
    output logic [7:0]       tx_inphase_out,        // In-phase level
    output logic [7:0]       tx_quadrature_out      // Quadrature level
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [6:0] QDIV_LAST =
        7'(tx_burst_pkg::QUARTER_CYCLES - 1);

    logic [6:0]  qdiv;
    logic [1:0]  phase;
    logic        burst_go;
    logic        mode;
    logic [tx_burst_pkg::DATA_W-1:0]   tx_inphase_data;
    logic [tx_burst_pkg::SAMPLE_W-1:0] tx_quadrature_data;
    logic [1:0]  base_delay_offset;
    logic        go_sampled;
    logic        stop_pending;
    logic [7:0]  stop_cnt;
    logic [7:0]  qcnt;
    logic [7:0]  envelope;
    tx_burst_pkg::seq_state_t state;
    tx_burst_pkg::seq_state_t next_state;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------

    // Quarter tick and tick falling edge
    wire quarter    = (qdiv == QDIV_LAST);
    wire tick_fall  = quarter && (phase == 2'd1);
    wire tick_level = (phase[1] == 1'b0);

    // Divider and quarter phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            qdiv  <= '0;
            phase <= '0;
        end
        else
        begin
            qdiv  <= quarter ? 7'd0 : qdiv + 7'd1;  // [RULE_20]
            phase <= quarter ? phase + 2'd1 : phase;
        end
    end

    // Tick output, high for first half of each tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_tick_interrupt <= 1'b0;
        else
            sample_tick_interrupt <= tick_level;    // [RULE_01]
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Address decode
    wire setup    = psel && !penable;
    wire wr_acc   = psel && penable && pwrite;
    wire hit_ctrl = (paddr == tx_burst_pkg::OFS_CTRL);
    wire hit_i    = (paddr == tx_burst_pkg::OFS_INPHASE);
    wire hit_q    = (paddr == tx_burst_pkg::OFS_QUADRATURE);
    wire hit_dly  = (paddr == tx_burst_pkg::OFS_BASE_DELAY);
    wire hit_stat = (paddr == tx_burst_pkg::OFS_STATUS);
    wire mapped   = hit_ctrl || hit_i || hit_q || hit_dly || hit_stat;
    wire load_i   = wr_acc && hit_i;
    wire shift_en = tick_fall && go_sampled && mode;

    // Read multiplexer
    wire [31:0] rd_ctrl = {30'd0, mode, burst_go};
    wire [31:0] rd_i    = {22'd0, tx_inphase_data};
    wire [31:0] rd_q    = {24'd0, tx_quadrature_data};
    wire [31:0] rd_dly  = {30'd0, base_delay_offset};
    wire [31:0] rd_stat = {23'd0, stop_pending, go_sampled,
                           sample_tick_interrupt, 2'd0, state,
                           power_amp_enable};
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                          hit_i    ? rd_i    :
                          hit_q    ? rd_q    :
                          hit_dly  ? rd_dly  :
                          hit_stat ? rd_stat : 32'h0000_0000;

    // Zero wait state answer
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    // Control and sample registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            burst_go           <= tx_burst_pkg::CTRL_GO_RST;
            mode               <= tx_burst_pkg::CTRL_MODE_RST;
            tx_quadrature_data <= '0;
            base_delay_offset  <= '0;
        end
        else if (wr_acc)
        begin
            if (hit_ctrl)
            begin
                burst_go <= pwdata[tx_burst_pkg::BIT_BURST_GO];
                mode     <= pwdata[tx_burst_pkg::BIT_MODE];   // [RULE_18]
            end
            if (hit_q)
                tx_quadrature_data <= pwdata[7:0];
            if (hit_dly)
                base_delay_offset <= pwdata[1:0];             // [RULE_11]
        end
    end

    // Transmit data: write loads, tick shifts right, bit 0 first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_inphase_data <= '0;
            mod_bit         <= 1'b0;
        end
        else if (load_i)
            tx_inphase_data <= pwdata[tx_burst_pkg::DATA_W-1:0];
        else if (shift_en)
        begin
            mod_bit         <= tx_inphase_data[0];            // [RULE_07]
            tx_inphase_data <= tx_inphase_data >> 1;
        end
    end

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------

    // Offset adds quarter ticks to start and stop alike
    wire [7:0] dly      = {6'd0, base_delay_offset};
    wire [7:0] hold_end = tx_burst_pkg::HOLD_Q + dly;         // [RULE_10]
    wire [7:0] stop_end = tx_burst_pkg::FLUSH_Q + dly;        // [RULE_13]
    wire       hold_done  = quarter && (qcnt == hold_end - 8'd1);
    wire       ramp_done  = quarter &&
                            (qcnt == tx_burst_pkg::RAMP_Q - 8'd1);
    wire       decay_done = quarter &&
                            (qcnt == tx_burst_pkg::DECAY_Q - 8'd1);
    wire       stop_due   = stop_pending && (stop_cnt >= stop_end - 8'd1);

    // Sampled go at tick fall only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            go_sampled <= 1'b0;
        else if (tick_fall)
            go_sampled <= burst_go && mode;                   // [RULE_03]
    end

    // Time since sampled fall, in quarters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_pending <= 1'b0;
            stop_cnt     <= '0;
        end
        else if (tick_fall && go_sampled && !burst_go)
        begin
            stop_pending <= 1'b1;                             // [RULE_08]
            stop_cnt     <= '0;
        end
        else if (state == tx_burst_pkg::ST_DECAY || !mode)
            stop_pending <= 1'b0;
        else if (quarter && stop_pending && stop_cnt != 8'hff)
            stop_cnt <= stop_cnt + 8'd1;
    end

    // Next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            tx_burst_pkg::ST_IDLE:
                if (mode && tick_fall && burst_go)
                    next_state = tx_burst_pkg::ST_HOLD;
            tx_burst_pkg::ST_HOLD:
                if (hold_done)
                    next_state = tx_burst_pkg::ST_RAMP_UP;    // [RULE_04]
            tx_burst_pkg::ST_RAMP_UP:
                if (ramp_done)
                    next_state = tx_burst_pkg::ST_BURST;      // [RULE_06]
            tx_burst_pkg::ST_BURST:
                if (stop_due && quarter)
                    next_state = tx_burst_pkg::ST_DECAY;      // [RULE_14]
            tx_burst_pkg::ST_DECAY:
                if (decay_done)
                    next_state = tx_burst_pkg::ST_IDLE;       // [RULE_09]
            default:
                next_state = tx_burst_pkg::ST_IDLE;
        endcase
        if (!mode)
            next_state = tx_burst_pkg::ST_IDLE;
    end

    // State and quarter count since entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= tx_burst_pkg::ST_IDLE;
            qcnt  <= '0;
        end
        else
        begin
            state <= next_state;
            if (next_state != state)
                qcnt <= '0;
            else if (quarter)
                qcnt <= qcnt + 8'd1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Fixed ramp envelope, the only level shaping
    wire [7:0] ramp_lvl = 8'(qcnt * tx_burst_pkg::RAMP_STEP);
    wire [7:0] fall_lvl = 8'((qcnt + 8'd1) * tx_burst_pkg::RAMP_STEP);
    always_comb
    begin
        unique case (state)
            tx_burst_pkg::ST_RAMP_UP: envelope = ramp_lvl;
            tx_burst_pkg::ST_BURST:   envelope = tx_burst_pkg::PEAK_LEVEL;
            tx_burst_pkg::ST_DECAY:
                envelope = tx_burst_pkg::PEAK_LEVEL - fall_lvl;   // [RULE_09]
            default:                  envelope = 8'h00;
        endcase
    end

    // Enable follows ramp start and decay end; analog holds it high
    wire next_pa = !mode ||                                   // [RULE_19]
                   (next_state == tx_burst_pkg::ST_RAMP_UP) ||
                   (next_state == tx_burst_pkg::ST_BURST) ||
                   (next_state == tx_burst_pkg::ST_DECAY);    // [RULE_05]

    // Registered output levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_amp_enable  <= 1'b0;
            tx_inphase_out    <= '0;
            tx_quadrature_out <= '0;
        end
        else
        begin
            power_amp_enable <= next_pa;
            if (mode)
            begin
                tx_inphase_out    <= envelope;                // [RULE_15]
                tx_quadrature_out <= envelope;
            end
            else
            begin
                tx_inphase_out    <= tx_inphase_data[7:0];    // [RULE_16]
                tx_quadrature_out <= tx_quadrature_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_tick_low_half;
        @(posedge pclk) disable iff (!presetn)
        $fell(sample_tick_interrupt) |-> !sample_tick_interrupt[*8];
    endproperty
    a_tick_low_half: assert property (p_tick_low_half) // [RULE_01]
        else $error("tick low phase too short");

    property p_go_at_fall;
        @(posedge pclk) disable iff (!presetn)
        $changed(go_sampled) |-> $past(tick_fall);
    endproperty
    a_go_at_fall: assert property (p_go_at_fall) // [RULE_03]
        else $error("burst-go sampled off the tick fall");

    property p_hold_len;
        @(posedge pclk) disable iff (!presetn)
        (state == tx_burst_pkg::ST_RAMP_UP &&
         $past(state) == tx_burst_pkg::ST_HOLD)
        |-> $past(qcnt) == tx_burst_pkg::HOLD_Q + dly - 8'd1;
    endproperty
    a_hold_len: assert property (p_hold_len) // [RULE_04]
        else $error("hold span wrong");

    property p_pa_at_ramp;
        @(posedge pclk) disable iff (!presetn)
        (mode && $past(mode) && $rose(power_amp_enable))
        |-> state == tx_burst_pkg::ST_RAMP_UP && qcnt == 8'd0
            && tx_inphase_out == 8'h00;
    endproperty
    a_pa_at_ramp: assert property (p_pa_at_ramp) // [RULE_05]
        else $error("enable rise not at ramp start");

    property p_ramp_len;
        @(posedge pclk) disable iff (!presetn)
        (state == tx_burst_pkg::ST_BURST &&
         $past(state) == tx_burst_pkg::ST_RAMP_UP)
        |-> $past(qcnt) == tx_burst_pkg::RAMP_Q - 8'd1
            ##1 tx_inphase_out == tx_burst_pkg::PEAK_LEVEL || !mode;
    endproperty
    a_ramp_len: assert property (p_ramp_len) // [RULE_06]
        else $error("ramp span wrong");

    property p_shift_lsb;
        @(posedge pclk) disable iff (!presetn)
        (shift_en && !load_i) |=> mod_bit == $past(tx_inphase_data[0]);
    endproperty
    a_shift_lsb: assert property (p_shift_lsb) // [RULE_07]
        else $error("shift order wrong");

    property p_decay_start;
        @(posedge pclk) disable iff (!presetn)
        (state == tx_burst_pkg::ST_DECAY &&
         $past(state) == tx_burst_pkg::ST_BURST)
        |-> $past(stop_cnt) >= tx_burst_pkg::FLUSH_Q + dly - 8'd1;
    endproperty
    a_decay_start: assert property (p_decay_start) // [RULE_08]
        else $error("decay began before flush ended");

    property p_pa_fall;
        @(posedge pclk) disable iff (!presetn)
        (mode && $past(mode, 2) && $fell(power_amp_enable))
        |-> $past(state) == tx_burst_pkg::ST_DECAY
            && $past(qcnt) == tx_burst_pkg::DECAY_Q - 8'd1;
    endproperty
    a_pa_fall: assert property (p_pa_fall) // [RULE_09]
        else $error("enable fall not at decay end");

    property p_burst_holds;
        @(posedge pclk) disable iff (!presetn)
        (state == tx_burst_pkg::ST_BURST && mode && !stop_pending)
        |=> state == tx_burst_pkg::ST_BURST;
    endproperty
    a_burst_holds: assert property (p_burst_holds) // [RULE_14]
        else $error("burst ended while go held");

    property p_analog_pa;
        @(posedge pclk) disable iff (!presetn)
        (!mode && !$past(mode)) |-> power_amp_enable
            ##1 (mode || tx_quadrature_out == $past(tx_quadrature_data));
    endproperty
    a_analog_pa: assert property (p_analog_pa) // [RULE_19]
        else $error("analog mode enable or sample wrong");

endmodule

`default_nettype wire

// ==== bench/dsp_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// DSP side: APB master that loads transmit data and control
// ------------------------------------------------------------
module dsp_model
(
    input  wire logic        pclk,    // Bus clock
    input  wire logic        pready,  // Slave ready
    input  wire logic        pslverr, // Slave error
    input  wire logic [31:0] prdata,  // Read data
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Direction
    output logic [7:0]       paddr,   // Byte address
    output logic [31:0]      pwdata,  // Write data
    output logic             hung     // No ready within bound
);
    // Bus idle at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        hung    = 1'b0;
    end

    // One transfer, held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        int   n;
        logic ok;
        n  = 0;
        ok = 1'b0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        while (!ok && n < 16)
        begin
            @(posedge pclk);
            n++;
            ok = (pready === 1'b1);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!ok)
            hung <= 1'b1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic err);
        xfer(1'b0, a, 32'h0, d, err);
    endtask

    // Dibits first, then offset, then go in digital mode
    task automatic start_burst(input logic [9:0] data,
                               input logic [1:0] d);
        wr_reg(tx_burst_pkg::OFS_INPHASE, {22'h0, data});
        wr_reg(tx_burst_pkg::OFS_BASE_DELAY, {30'h0, d});
        wr_reg(tx_burst_pkg::OFS_CTRL, 32'h3);
    endtask

    // Samples trimmed by one sixteenth for power match
    task automatic analog_sample(input logic [7:0] i,
                                 input logic [7:0] q);
        wr_reg(tx_burst_pkg::OFS_INPHASE, {24'h0, i - (i >> 4)});
        wr_reg(tx_burst_pkg::OFS_QUADRATURE, {24'h0, q - (q >> 4)});
    endtask
endmodule

`default_nettype wire

// ==== bench/tx_burst_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tx_burst_sequencer_tb;
    localparam int Q = 103; // Quarter tick in clocks

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hung;
    logic        tick;
    logic        pa;
    logic        mod_bit;
    logic [7:0]  out_i;
    logic [7:0]  out_q;
    logic [7:0]  last_out;
    int          failures = 0;
    int          tests_run = 0;

    // ------------------------------------------------------------
    // Design, bus partner and clock
    // ------------------------------------------------------------
    tx_burst_sequencer i_tx_burst_sequencer
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_tick_interrupt(tick),
        .power_amp_enable(pa), .mod_bit(mod_bit),
        .tx_inphase_out(out_i), .tx_quadrature_out(out_q)
    );

    dsp_model i_dsp_model
    (
        .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .hung(hung)
    );

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared checking and waiting
    // ------------------------------------------------------------
    task automatic results();
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic near(input int n, input int e, input int t);
        check(32'((n >= e - t && n <= e + t) ? e : n), 32'(e));
    endtask

    // Clocks until pa, in-phase level or tick meets the value
    task automatic wait_sig(input int which, input logic [7:0] v,
                            output int n);
        logic hit;
        n   = 0;
        hit = 1'b0;
        while (!hit && n < 40000)
        begin
            last_out = out_i;
            @(posedge pclk);
            #1;
            n++;
            case (which)
                0:       hit = (pa === v[0]);
                1:       hit = (out_i === v);
                default: hit = (tick === v[0]);
            endcase
        end
        if (!hit)
        begin
            failures++;
            results();
        end
    endtask

    // Bus hang ends the run
    always @(posedge hung)
    begin
        failures++;
        results();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        check(32'(pa), 32'h0);
        check(32'(out_i), 32'h0);
        i_dsp_model.rd_reg(tx_burst_pkg::OFS_CTRL, rd, err);
        check(rd, 32'h2);
        i_dsp_model.rd_reg(tx_burst_pkg::OFS_STATUS, rd, err);
        check(rd & 32'h18f, 32'h0);
        i_dsp_model.wr_reg(8'h14, 32'h1);
        i_dsp_model.rd_reg(8'h14, rd, err);
        check({rd[30:0], err}, 32'h1);
        i_dsp_model.rd_reg(tx_burst_pkg::OFS_CTRL, rd, err);
        check(rd, 32'h2);
    endtask

    task automatic t_tick();
        int n;
        wait_sig(2, 8'h0, n);
        wait_sig(2, 8'h1, n);
        near(n, 2 * Q, 0);
        wait_sig(2, 8'h0, n);
        near(n, 2 * Q, 0);
    endtask

    // Bits leave LSB first, register shifts right each tick
    task automatic shift_once(input logic b, input logic [31:0] v);
        logic [31:0] rd;
        logic        err;
        int          n;
        wait_sig(2, 8'h1, n);
        wait_sig(2, 8'h0, n);
        repeat (3) @(negedge pclk);
        check(32'(mod_bit), 32'(b));
        i_dsp_model.rd_reg(tx_burst_pkg::OFS_INPHASE, rd, err);
        check(rd, v);
    endtask

    task automatic t_burst(input logic [1:0] d, input int extra);
        logic [31:0] rd;
        logic        err;
        logic [31:0] v;
        int          n;
        wait_sig(2, 8'h0, n);
        wait_sig(2, 8'h1, n);
        i_dsp_model.start_burst(10'h2d5, d);
        i_dsp_model.rd_reg(tx_burst_pkg::OFS_BASE_DELAY, rd, err);
        check(rd, 32'(d));
        wait_sig(2, 8'h0, n);
        wait_sig(0, 8'h1, n);
        near(n, (38 + d) * Q, 3);
        check(32'(last_out), 32'h0);
        check(32'(out_i <= tx_burst_pkg::RAMP_STEP), 32'h1);
        wait_sig(1, tx_burst_pkg::PEAK_LEVEL, n);
        near(n, 24 * Q, 3);
        check(32'(out_q), 32'(tx_burst_pkg::PEAK_LEVEL));
        wait_sig(2, 8'h1, n);
        i_dsp_model.wr_reg(tx_burst_pkg::OFS_INPHASE, 32'h2b6);
        shift_once(1'b0, 32'h15b);
        shift_once(1'b1, 32'h0ad);
        v = 32'h0ad;
        repeat (extra)
        begin
            shift_once(v[0], v >> 1);
            v = v >> 1;
        end
        check(32'(pa), 32'h1);
        wait_sig(2, 8'h1, n);
        i_dsp_model.wr_reg(tx_burst_pkg::OFS_CTRL, 32'h2);
        wait_sig(2, 8'h0, n);
        wait_sig(0, 8'h0, n);
        near(n, (78 + d) * Q, 3);
        check(32'(out_i), 32'h0);
    endtask

    task automatic t_analog();
        int n;
        wait_sig(2, 8'h1, n);
        i_dsp_model.wr_reg(tx_burst_pkg::OFS_CTRL, 32'h0);
        i_dsp_model.analog_sample(8'ha5, 8'h5c);
        repeat (3) @(negedge pclk);
        check(32'(pa), 32'h1);
        check(32'(out_i), 32'h9b);
        check(32'(out_q), 32'h57);
        i_dsp_model.wr_reg(tx_burst_pkg::OFS_CTRL, 32'h1);
        wait_sig(2, 8'h0, n);
        wait_sig(2, 8'h1, n);
        check(32'(pa), 32'h1);
        i_dsp_model.wr_reg(tx_burst_pkg::OFS_CTRL, 32'h2);
        repeat (3) @(negedge pclk);
        check(32'(pa), 32'h0);
        check(32'(out_i), 32'h0);
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        last_out = 8'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tick();
        for (int d = 0; d < 4; d++)
            t_burst(2'(d), d);
        t_analog();
        results();
    end
endmodule

`default_nettype wire
